/* File: dhg_cond_if.sv */
// Carrier between the register bank and the serial-bus input conditioner.
interface dhg_cond_if;
  logic [3:0] filter_depth;
  logic [2:0] sda_hold;
  logic       scl_clean;
  logic       sda_clean;
  modport regs (output filter_depth, output sda_hold, input scl_clean, input sda_clean);
  modport cond (input filter_depth, input sda_hold, output scl_clean, output sda_clean);
endinterface

/* File: dhg_global_regs.sv */
// Global identifier, status, parity threshold, watchdog and serial-bus control registers.
// What this block does
// - Read-only identifier: revision high, mask low
// - Checksum bit set only after passing load
// - Init-done bit set when loading completes
// - Status bit 4 shows reference clock valid
// - Port flag set when errors reach threshold
// - Threshold upper byte register, resets to one
// - Threshold lower byte register, resets to zero
// - Watchdog aborts transaction after units of 2ms
// - Watchdog disable bit, resets to enabled
// - Lockout bit blocks remote register writes
// - Lockout leaves remote local-bus accesses alone
// - SDA hold equals field times 50ns
// - Glitch filter rejects field times 5ns
// - Parity counted only while checker enabled
// - Reload trigger reruns load, done bit polls
module dhg_global_regs
  import dhg_pkg::*;
#(
  parameter int         NPORT     = 4,
  parameter int         WD_TICK   = dhg_pkg::WD_TICK_CYC,
  parameter logic [3:0] REV_CODE  = 4'hA,  // Arbitrary value.
  parameter logic [3:0] MASK_CODE = 4'h3   // Arbitrary value.
)(
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_remote_i,
  output logic      [7:0]       reg_rdata_o,
  output logic                  reg_rvalid_o,
  output logic                  reg_wr_blocked_o,
  input  wire logic             fwd_req_i,
  output logic                  fwd_grant_o,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  scl_clean_o,
  output logic                  sda_clean_o,
  input  wire logic             rom_reload_i,
  output logic                  rom_load_start_o,
  input  wire logic             rom_load_done_i,
  input  wire logic             rom_cksum_ok_i,
  input  wire logic             ref_clock_ok_i,
  input  wire logic             parity_check_en_i,
  input  wire logic [NPORT-1:0] par_err_i,
  input  wire logic [NPORT-1:0] par_clr_i,
  output logic      [NPORT-1:0] par_flag_o,
  input  wire logic             cc_start_i,
  input  wire logic             cc_done_i,
  output logic                  cc_abort_o
);
  import dhg_pkg::*;

  localparam int TW = $clog2(WD_TICK + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]                   par_hi;
    logic [7:0]                   par_lo;
    logic [6:0]                   wd_time;
    logic                         wd_off;
    logic                         lock;
    logic [2:0]                   hold;
    logic [3:0]                   filt;
    logic [7:0]                   rdata;
    logic                         rvalid;
    logic                         blocked;
    logic [1:0]                   ref_sync;
    dhg_init_state_t              init_state;
    logic                         load_start;
    logic                         cksum_ok;
    logic [NPORT-1:0][15:0]       par_cnt;
    logic [NPORT-1:0]             par_flag;
    dhg_wd_state_t                wd_state;
    logic [6:0]                   wd_units;
    logic [TW-1:0]                wd_tick;
    logic                         abort;
  } dhg_regs_state_t;

  dhg_regs_state_t st_r;
  dhg_regs_state_t st_nxt;
  logic [15:0]     thresh;
  logic [7:0]      status;
  logic            wr_ok;
  logic            tick_end;

  dhg_cond_if cif ();

  dhg_i2c_cond u_cond (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .cif      (cif)
  );

  assign cif.filter_depth = st_r.filt;
  assign cif.sda_hold     = st_r.hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Saturating increment of a parity error count.
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction

  always_comb begin
    thresh = {st_r.par_hi, st_r.par_lo};
    status = 8'h00;
    status[STS_CKSUM_BIT]  = st_r.cksum_ok && (st_r.init_state == INIT_DONE);
    status[STS_INIT_BIT]   = (st_r.init_state == INIT_DONE);
    status[STS_REFERENCE_CLOCK_INPUT_BIT] = st_r.ref_sync[1];
    wr_ok    = reg_wr_i && !(reg_remote_i && st_r.lock);
    tick_end = (st_r.wd_tick == TW'(WD_TICK - 1));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rvalid   = 1'b0;
    st_nxt.blocked  = reg_wr_i && !wr_ok;
    st_nxt.abort    = 1'b0;
    st_nxt.ref_sync = {st_r.ref_sync[0], ref_clock_ok_i};

    if (reg_rd_i) begin
      st_nxt.rvalid = 1'b1;
      unique case (reg_addr_i)
        ADDR_REV:    st_nxt.rdata = {REV_CODE, MASK_CODE};
        ADDR_STATUS: st_nxt.rdata = status;
        ADDR_PAR_HI: st_nxt.rdata = st_r.par_hi;
        ADDR_PAR_LO: st_nxt.rdata = st_r.par_lo;
        ADDR_WDOG:   st_nxt.rdata = {st_r.wd_time, st_r.wd_off};
        ADDR_SBC1:   st_nxt.rdata = {st_r.lock, st_r.hold, st_r.filt};
        default:     st_nxt.rdata = 8'h00;
      endcase
    end

    // Identifier and status offsets fall to the default and are not stored.
    if (wr_ok) begin
      unique case (reg_addr_i)
        ADDR_PAR_HI: st_nxt.par_hi = reg_wdata_i;
        ADDR_PAR_LO: st_nxt.par_lo = reg_wdata_i;
        ADDR_WDOG: begin
          st_nxt.wd_time = reg_wdata_i[WD_TIME_MSB:WD_TIME_LSB];
          st_nxt.wd_off  = reg_wdata_i[WD_OFF_BIT];
        end
        ADDR_SBC1: begin
          st_nxt.lock = reg_wdata_i[SBC_LOCK_BIT];
          st_nxt.hold = reg_wdata_i[HOLD_MSB:HOLD_LSB];
          st_nxt.filt = reg_wdata_i[FILT_MSB:FILT_LSB];
        end
        default: ;
      endcase
    end

    // Configuration load; a reload request wins over a completing load.
    st_nxt.load_start = 1'b0;
    if (rom_reload_i) begin
      st_nxt.init_state = INIT_LOAD;
      st_nxt.load_start = 1'b1;
      st_nxt.cksum_ok   = 1'b0;
    end else begin
      unique case (st_r.init_state)
        INIT_LOAD: if (rom_load_done_i) begin
          st_nxt.init_state = INIT_DONE;
          st_nxt.cksum_ok   = rom_cksum_ok_i;
        end
        INIT_DONE: ;
        default:   st_nxt.init_state = INIT_LOAD;
      endcase
    end

    // Parity counters; an error in the clearing cycle still counts.
    // The flag is judged against the threshold as it stands after this edge.
    for (int p = 0; p < NPORT; p++) begin
      if (par_clr_i[p]) begin
        st_nxt.par_cnt[p] = 16'h0000;
      end
      if (par_err_i[p] && parity_check_en_i) begin
        st_nxt.par_cnt[p] = sat_inc(par_clr_i[p] ? 16'h0000 : st_r.par_cnt[p]);
      end
      st_nxt.par_flag[p] = (st_nxt.par_cnt[p] >= {st_nxt.par_hi, st_nxt.par_lo});
    end

    // Control-channel watchdog. A zero timeout is treated as one unit.
    unique case (st_r.wd_state)
      WD_IDLE: if (cc_start_i && !st_r.wd_off) begin
        st_nxt.wd_state = WD_RUN;
        st_nxt.wd_units = st_r.wd_time;
        st_nxt.wd_tick  = '0;
      end
      WD_RUN: begin
        if (cc_done_i || st_r.wd_off) begin
          st_nxt.wd_state = WD_IDLE;
        end else if (tick_end) begin
          st_nxt.wd_tick = '0;
          if (st_r.wd_units <= 7'h01) begin
            st_nxt.abort    = 1'b1;
            st_nxt.wd_state = WD_IDLE;
          end else begin
            st_nxt.wd_units = 7'(st_r.wd_units - 7'h01);
          end
        end else begin
          st_nxt.wd_tick = TW'(st_r.wd_tick + 1'b1);
        end
      end
      default: st_nxt.wd_state = WD_IDLE;
    endcase

    if (!resetn_i) begin
      st_nxt            = '0;
      st_nxt.par_hi     = PAR_HI_RST;
      st_nxt.par_lo     = PAR_LO_RST;
      st_nxt.wd_time    = WD_TIME_RST;
      st_nxt.wd_off     = WD_OFF_RST;
      st_nxt.lock       = SBC_LOCK_RST;
      st_nxt.hold       = HOLD_RST;
      st_nxt.filt       = FILT_RST;
      st_nxt.init_state = INIT_LOAD;
      st_nxt.load_start = 1'b1;
      st_nxt.wd_state   = WD_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign reg_rdata_o      = st_r.rdata;
  assign reg_rvalid_o     = st_r.rvalid;
  assign reg_wr_blocked_o = st_r.blocked;
  assign fwd_grant_o      = fwd_req_i;
  assign scl_clean_o      = cif.scl_clean;
  assign sda_clean_o      = cif.sda_clean;
  assign rom_load_start_o = st_r.load_start;
  assign par_flag_o       = st_r.par_flag;
  assign cc_abort_o       = st_r.abort;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_reload;
    rom_reload_i;
  endsequence

  sequence s_restart;
    ##1 (rom_load_start_o && !status[STS_INIT_BIT] && !status[STS_CKSUM_BIT]);
  endsequence

  a_id_readback: assert property (
    reg_rd_i && reg_addr_i == ADDR_REV |=> reg_rvalid_o && reg_rdata_o == {REV_CODE, MASK_CODE})
    else $error("Identifier read returned the wrong code");

  a_load_status: assert property (
    st_r.init_state == INIT_LOAD && rom_load_done_i && !rom_reload_i
    |=> status[STS_INIT_BIT] && status[STS_CKSUM_BIT] == $past(rom_cksum_ok_i))
    else $error("Load completion not reflected in status");

  a_reload_restart: assert property (
    s_reload |-> s_restart)
    else $error("Reload did not restart the configuration load");

  a_reference_clock_input_read: assert property (
    reg_rd_i && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[STS_REFERENCE_CLOCK_INPUT_BIT] == $past(ref_clock_ok_i, 3))
    else $error("Reference clock status does not follow the detector");

  a_thresh_reset: assert property (
    $rose(resetn_i) |-> st_r.par_hi == PAR_HI_RST && st_r.par_lo == PAR_LO_RST)
    else $error("Parity threshold bytes not at reset values");

  a_par_flag: assert property (
    par_flag_o[0] == (st_r.par_cnt[0] >= thresh))
    else $error("Port flag disagrees with count against threshold");

  a_par_gate: assert property (
    !parity_check_en_i && !par_clr_i[0] |=> $stable(st_r.par_cnt[0]))
    else $error("Parity count moved while the checker was disabled");

  a_rem_lockout: assert property (
    reg_wr_i && reg_remote_i && st_r.lock
    |=> $stable({st_r.par_hi, st_r.par_lo, st_r.wd_time, st_r.wd_off, st_r.lock, st_r.hold,
                 st_r.filt}) && reg_wr_blocked_o)
    else $error("Remote write passed the lockout");

  a_wd_abort: assert property (
    cc_abort_o |-> $past(st_r.wd_state == WD_RUN) && $past(tick_end) && $past(st_r.wd_units) <= 7'h01)
    else $error("Watchdog aborted at the wrong moment");

  a_wd_disable: assert property (
    st_r.wd_off |=> st_r.wd_state == WD_IDLE && !cc_abort_o)
    else $error("Disabled watchdog kept running");

  a_fwd_unlocked: assert property (
    st_r.lock && fwd_req_i |-> fwd_grant_o)
    else $error("Lockout blocked a forwarded local-bus access");

  a_status_ro: assert property (
    wr_ok && reg_addr_i == ADDR_STATUS && !rom_reload_i && !rom_load_done_i
    |=> $stable(st_r.init_state) && $stable(st_r.cksum_ok))
    else $error("Host write changed the status register");
endmodule

/* File: dhg_global_regs_tb.sv */
// Self-checking bench for the global status register bank.
module dhg_global_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dhg_pkg::*;
  localparam int         WD = 4;
  localparam logic [3:0] RV = 4'h6;  // Arbitrary value.
  localparam logic [3:0] MK = 4'h9;  // Arbitrary value.
  logic       clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_remote_i, fwd_req_i, fwd_grant_o;
  logic       scl_i, sda_i, scl_clean_o, sda_clean_o, rom_reload_i, rom_load_start_o;
  logic       rom_load_done_i, rom_cksum_ok_i, ref_clock_ok_i, parity_check_en_i;
  logic       cc_start_i, cc_done_i, cc_abort_o, reg_rvalid_o, reg_wr_blocked_o;
  logic       ld_cksum, blk, ab;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, ld_delay;
  logic [3:0] par_err_i, par_clr_i, par_flag_o;
  int         errors, checks_done, seed, k, n, h, d, p, t, ks, kd;

  dhg_global_regs #(.WD_TICK(WD), .REV_CODE(RV), .MASK_CODE(MK)) u_dhg_global_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_remote_i(reg_remote_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_wr_blocked_o(reg_wr_blocked_o), .fwd_req_i(fwd_req_i), .fwd_grant_o(fwd_grant_o),
    .scl_i(scl_i), .sda_i(sda_i), .scl_clean_o(scl_clean_o), .sda_clean_o(sda_clean_o),
    .rom_reload_i(rom_reload_i), .rom_load_start_o(rom_load_start_o),
    .rom_load_done_i(rom_load_done_i), .rom_cksum_ok_i(rom_cksum_ok_i),
    .ref_clock_ok_i(ref_clock_ok_i), .parity_check_en_i(parity_check_en_i),
    .par_err_i(par_err_i), .par_clr_i(par_clr_i), .par_flag_o(par_flag_o),
    .cc_start_i(cc_start_i), .cc_done_i(cc_done_i), .cc_abort_o(cc_abort_o));

  dhg_rom_model u_dhg_rom_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_i(rom_load_start_o), .delay_i(ld_delay),
    .cksum_i(ld_cksum), .done_o(rom_load_done_i), .cksum_o(rom_cksum_ok_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    tick();
    chk("rvalid", 16'h0001, {15'h0, reg_rvalid_o});
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    reg_rd_i = 1'b0;
    tick();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic rem);
    reg_wr_i     = 1'b1;
    reg_addr_i   = a;
    reg_wdata_i  = v;
    reg_remote_i = rem;
    tick();
    blk          = reg_wr_blocked_o;
    reg_wr_i     = 1'b0;
    reg_remote_i = 1'b0;
    tick();
  endtask

  task automatic quiet(input int c);
    ab = 1'b0;
    repeat (c) begin
      tick();
      ab = ab | cc_abort_o;
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, reg_remote_i, fwd_req_i, rom_reload_i} = 6'h00;
    {ref_clock_ok_i, cc_start_i, cc_done_i, blk, ab} = 5'h00;
    {reg_addr_i, reg_wdata_i, par_err_i, par_clr_i} = 24'h000000;
    {scl_i, sda_i, parity_check_en_i, ld_cksum} = 4'hF;
    ld_delay    = 8'h03;
    errors      = 0;
    checks_done = 0;
    seed        = 32'hac31afde;
    repeat (16) tick();
    resetn_i = 1'b1;
    repeat (8) tick();
    rd(ADDR_REV, {RV, MK});
    wr(ADDR_REV, 8'h5A, 1'b0);
    rd(ADDR_REV, {RV, MK});
    rd(ADDR_PAR_HI, 8'h01);
    rd(ADDR_PAR_LO, 8'h00);
    rd(ADDR_WDOG, 8'hFE);
    rd(ADDR_SBC1, 8'h1C);
    rd(ADDR_STATUS, 8'hC0);
    wr(ADDR_STATUS, 8'hFF, 1'b0);
    rd(ADDR_STATUS, 8'hC0);
    rd(8'h20, 8'h00);
    $display("test reset_values done");
    ref_clock_ok_i = 1'b1;
    repeat (4) tick();
    rd(ADDR_STATUS, 8'hD0);
    ld_delay     = 8'h08;
    ld_cksum     = 1'b0;
    rom_reload_i = 1'b1;
    tick();
    rom_reload_i = 1'b0;
    chk("load_start", 16'h0001, {15'h0, rom_load_start_o});
    rd(ADDR_STATUS, 8'h10);
    repeat (12) tick();
    rd(ADDR_STATUS, 8'h50);
    $display("test status done");
    for (t = 0; t < 4; t++) begin
      n = 2 + ($random(seed) & 7);
      p = $random(seed) & 3;
      wr(ADDR_PAR_HI, 8'h00, 1'b0);
      wr(ADDR_PAR_LO, n[7:0], 1'b0);
      rd(ADDR_PAR_LO, n[7:0]);
      parity_check_en_i = 1'b0;
      par_err_i[p]      = 1'b1;
      repeat (n) tick();
      par_err_i         = 4'h0;
      parity_check_en_i = 1'b1;
      tick();
      chk("flag_off", 16'h0000, {12'h0, par_flag_o});
      par_err_i[p] = 1'b1;
      repeat (n - 1) tick();
      par_err_i = 4'h0;
      tick();
      chk("flag_below", 16'h0000, {12'h0, par_flag_o});
      par_err_i[p] = 1'b1;
      tick();
      par_err_i = 4'h0;
      tick();
      chk("flag_at", 16'h0001 << p, {12'h0, par_flag_o});
      par_clr_i[p] = 1'b1;
      tick();
      par_clr_i = 4'h0;
      tick();
      chk("flag_clr", 16'h0000, {12'h0, par_flag_o});
    end
    $display("test parity done");
    for (t = 1; t < 4; t++) begin
      wr(ADDR_WDOG, {t[6:0], 1'b0}, 1'b0);
      cc_start_i = 1'b1;
      tick();
      cc_start_i = 1'b0;
      k = 0;
      while (cc_abort_o !== 1'b1) begin
        tick();
        k++;
        if (k > 100) begin
          errors++;
          conclude();
        end
      end
      chk("abort_time", 16'(t * WD), 16'(k));
      tick();
      chk("abort_len", 16'h0000, {15'h0, cc_abort_o});
    end
    wr(ADDR_WDOG, 8'h03, 1'b0);
    cc_start_i = 1'b1;
    tick();
    cc_start_i = 1'b0;
    quiet(12);
    chk("abort_disabled", 16'h0000, {15'h0, ab});
    wr(ADDR_WDOG, 8'h02, 1'b0);
    cc_start_i = 1'b1;
    tick();
    cc_start_i = 1'b0;
    cc_done_i  = 1'b1;
    tick();
    cc_done_i = 1'b0;
    quiet(12);
    chk("abort_done", 16'h0000, {15'h0, ab});
    $display("test watchdog done");
    wr(ADDR_SBC1, 8'h9C, 1'b0);
    wr(ADDR_PAR_HI, 8'h55, 1'b1);
    chk("blocked", 16'h0001, {15'h0, blk});
    rd(ADDR_PAR_HI, 8'h00);
    wr(ADDR_SBC1, 8'h1C, 1'b1);
    chk("blocked", 16'h0001, {15'h0, blk});
    rd(ADDR_SBC1, 8'h9C);
    fwd_req_i = 1'b1;
    #1;
    chk("grant", 16'h0001, {15'h0, fwd_grant_o});
    tick();
    fwd_req_i = 1'b0;
    wr(ADDR_SBC1, 8'h1C, 1'b0);
    wr(ADDR_PAR_LO, 8'h33, 1'b1);
    chk("blocked", 16'h0000, {15'h0, blk});
    rd(ADDR_PAR_LO, 8'h33);
    $display("test lockout done");
    for (t = 0; t < 3; t++) begin
      d = 1 + ($random(seed) & 3);
      h = $random(seed) & 3;
      n = (d * 5 + 9) / 10;
      wr(ADDR_SBC1, {1'b0, h[2:0], d[3:0]}, 1'b0);
      repeat (4) tick();
      scl_i = 1'b0;
      repeat (n) tick();
      scl_i = 1'b1;
      ab    = 1'b0;
      repeat (n + 8) begin
        tick();
        ab = ab | ~scl_clean_o;
      end
      chk("scl_glitch", 16'h0000, {15'h0, ab});
      scl_i = 1'b0;
      sda_i = 1'b0;
      ks    = 0;
      kd    = 0;
      for (k = 1; k <= 60; k++) begin
        tick();
        if (ks == 0 && scl_clean_o === 1'b0) ks = k;
        if (kd == 0 && sda_clean_o === 1'b0) kd = k;
      end
      chk("scl_latency", 16'(n + 4), 16'(ks));
      chk("sda_latency", 16'(n + 4 + h * 5), 16'(kd));
      scl_i = 1'b1;
      sda_i = 1'b1;
      repeat (60) tick();
    end
    $display("test conditioner done");
    conclude();
  end
endmodule

/* File: dhg_i2c_cond.sv */
// Serial-bus input conditioner: synchroniser, glitch filter and internal SDA hold.
module dhg_i2c_cond
  import dhg_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  resetn_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  dhg_cond_if.cond   cif
);
  import dhg_pkg::*;

  typedef struct packed {
    logic [1:0]           scl_sync;
    logic [1:0]           sda_sync;
    logic                 scl_f;
    logic                 sda_f;
    logic [3:0]           scl_cnt;
    logic [3:0]           sda_cnt;
    logic [HOLD_TAPS-1:0] sda_line;
    logic                 scl_h;
    logic                 sda_h;
  } dhg_cond_state_t;

  dhg_cond_state_t st_r;
  dhg_cond_state_t st_nxt;
  logic [3:0]      filt_n;
  int              tap;

  // One filter step: the output follows the input only after it has differed
  // for more than the programmed number of cycles.
  function automatic logic [4:0] filt_step(input logic raw, input logic cur,
                                           input logic [3:0] cnt, input logic [3:0] n);
    if (raw == cur) begin
      return {cur, 4'h0};
    end else if (cnt >= n) begin
      return {raw, 4'h0};
    end else begin
      return {cur, 4'(cnt + 4'h1)};
    end
  endfunction

  always_comb begin
    filt_n = 4'(ceil_cycles(int'(cif.filter_depth) * FILT_UNIT_NS));
    tap    = int'(cif.sda_hold) * HOLD_UNIT_CYC;
    st_nxt = st_r;
    st_nxt.scl_sync = {st_r.scl_sync[0], scl_i};
    st_nxt.sda_sync = {st_r.sda_sync[0], sda_i};
    {st_nxt.scl_f, st_nxt.scl_cnt} = filt_step(st_r.scl_sync[1], st_r.scl_f,
                                               st_r.scl_cnt, filt_n);
    {st_nxt.sda_f, st_nxt.sda_cnt} = filt_step(st_r.sda_sync[1], st_r.sda_f,
                                               st_r.sda_cnt, filt_n);
    st_nxt.sda_line = {st_r.sda_line[HOLD_TAPS-2:0], st_r.sda_f};
    st_nxt.scl_h    = st_r.scl_f;
    st_nxt.sda_h    = (tap == 0) ? st_r.sda_f : st_r.sda_line[tap-1];
    if (!resetn_i) begin
      st_nxt = '{scl_sync: 2'h3, sda_sync: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
                 scl_cnt: 4'h0, sda_cnt: 4'h0, sda_line: '1, scl_h: 1'b1, sda_h: 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign cif.scl_clean = st_r.scl_h;
  assign cif.sda_clean = st_r.sda_h;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_scl_glitch_reject: assert property (
    $changed(st_r.scl_f) |-> $past(st_r.scl_sync[1]) == st_r.scl_f && $past(st_r.scl_cnt) >= $past(filt_n))
    else $error("SCL filter output changed before the input was stable long enough");

  a_sda_hold_delay: assert property (
    ($past(cif.sda_hold) == 3'h1) |-> st_r.sda_h == $past(st_r.sda_f, 6))
    else $error("SDA hold of one unit did not delay SDA by five cycles");
endmodule

/* File: dhg_pkg.sv */
// Shared constants and state encodings for the global status register bank.
package dhg_pkg;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam logic [7:0] ADDR_REV       = 8'h03;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_PAR_HI    = 8'h05;
  localparam logic [7:0] ADDR_PAR_LO    = 8'h06;
  localparam logic [7:0] ADDR_WDOG      = 8'h07;
  localparam logic [7:0] ADDR_SBC1      = 8'h08;
  localparam int         STS_CKSUM_BIT  = 7;
  localparam int         STS_INIT_BIT   = 6;
  localparam int         STS_REFERENCE_CLOCK_INPUT_BIT = 4;
  localparam int         WD_TIME_MSB    = 7;
  localparam int         WD_TIME_LSB    = 1;
  localparam int         WD_OFF_BIT     = 0;
  localparam int         SBC_LOCK_BIT   = 7;
  localparam int         HOLD_MSB       = 6;
  localparam int         HOLD_LSB       = 4;
  localparam int         FILT_MSB       = 3;
  localparam int         FILT_LSB       = 0;
  localparam logic [7:0] PAR_HI_RST     = 8'h01;
  localparam logic [7:0] PAR_LO_RST     = 8'h00;
  localparam logic [6:0] WD_TIME_RST    = 7'h7F;
  localparam logic       WD_OFF_RST     = 1'b0;
  localparam logic       SBC_LOCK_RST   = 1'b0;
  localparam logic [2:0] HOLD_RST       = 3'h1;
  localparam logic [3:0] FILT_RST       = 4'hC;
  localparam int         WD_UNIT_MS     = 2;
  localparam int         WD_TICK_CYC    = WD_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         HOLD_UNIT_NS   = 50;
  localparam int         FILT_UNIT_NS   = 5;
  localparam int         HOLD_MAX       = 7;

  // Least time in nanoseconds turned into whole clock cycles, rounded up.
  function automatic int ceil_cycles(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int         HOLD_UNIT_CYC  = ceil_cycles(HOLD_UNIT_NS);
  localparam int         HOLD_TAPS      = HOLD_MAX * HOLD_UNIT_CYC;

  typedef enum logic [1:0] {WD_IDLE = 2'b01, WD_RUN = 2'b10} dhg_wd_state_t;
  typedef enum logic [1:0] {INIT_LOAD = 2'b01, INIT_DONE = 2'b10} dhg_init_state_t;
endpackage

/* File: dhg_rom_model.sv */
// Fuse loader model answering load start requests after a programmable delay.
module dhg_rom_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       cksum_i,
  output logic            done_o,
  output logic            cksum_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  logic       busy_r;
  logic       tog_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      done_o <= 1'b0;
      tog_r  <= 1'b0;
    end else begin
      tog_r  <= ~tog_r;
      done_o <= 1'b0;
      if (start_i) begin
        busy_r <= 1'b1;
        cnt_r  <= delay_i;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  // Outside the done cycle the result toggles, so a stale sample shows up.
  assign cksum_o = done_o ? cksum_i : tog_r;
endmodule
